// ==== core/adc_ctl2_pkg.sv ====
// constants and state codes for the converter control-two block
// Operation
// - any write to control two aborts the running sequence
// - fast clear off: a complete flag clears only by writing one to it
// - fast clear on, compare off: reading result n clears flag n
// - fast clear on, compare on: writing result n clears flag n
// - stop entry with stop clock set switches to internal clock, sequence continues
// - internal clock rate ignores the prescaler; prescaler is bypassed
// - external triggers are ignored while in stop mode
// - a conversion spanning a run/stop change stores nothing, sets no flag
// - stop clock clear: sequence aborted at stop entry, restarted at exit
// - level/edge bit 4 and polarity bit 3 set trigger sensitivity
// - trigger enable bit 2 turns external triggering on or off
// - analog trigger source gets its digital input buffer enabled while trigger enable bit 2 is set
// - an enabled trigger starts a sequence on the qualifying event
// - control two is readable and writable at any time
// - sequence complete and compare events still raise interrupts in stop
// - sensitivity 00 falling, 01 rising, 10 low level, 11 high level
// - selector 0 picks channel 0-9 (above 9 is 9); 1 picks inputs 0-3
package adc_ctl2_pkg;
  localparam logic [7:0] OFS_CTL2  = 8'h02;
  localparam logic [7:0] OFS_TSRC  = 8'h10;
  localparam logic [7:0] OFS_FLAG  = 8'h11;
  localparam logic [7:0] OFS_COMPARE_ENABLE_PER_CONVERSION  = 8'h12;
  localparam logic [7:0] OFS_START = 8'h13;
  localparam logic [7:0] OFS_IST   = 8'h14;
  localparam logic [7:0] OFS_IMSK  = 8'h15;
  localparam logic [4:0] OFS_RES   = 5'h04;
  localparam int BIT_FAST_FLAG_CLEAR_ALL    = 6;
  localparam int BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE = 5;
  localparam int BIT_TLE     = 4;
  localparam int BIT_TPOL    = 3;
  localparam int BIT_TEN     = 2;
  localparam int BIT_TSEL    = 4;
  localparam int IST_SEQ     = 0;
  localparam int IST_CMP     = 1;
  localparam logic [7:0] CTL2_RST   = 8'h00;
  localparam logic [7:0] CTL2_WMASK = 8'h7f;
  localparam logic [4:0] TSRC_RST   = 5'h00;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [1:0] IST_RST    = 2'h0;
  localparam logic [3:0] LAST_CH    = 4'h9;
  localparam logic [3:0] NUM_TRIG   = 4'h4;
  localparam int NUM_CONV = 8;
  localparam int NUM_AN   = 10;
  localparam int NUM_PIN  = 15;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_PARK = 3'b100
  } seq_state_t;
endpackage

// ==== core/adc_ctl2_core.sv ====
// control-two logic of the converter sequencer with its flags
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module adc_ctl2_core (
  // clock, reset, enable
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_CE,
  // register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  // pins
  input  wire logic        I_STOP,
  input  wire logic [9:0]  I_AN_DIG,
  input  wire logic [3:0]  I_TRIG_PIN,
  // converter engine
  input  wire logic        I_CONV_BEGIN,
  input  wire logic        I_CONV_DONE,
  input  wire logic [2:0]  I_CONV_IDX,
  input  wire logic [7:0]  I_CONV_DATA,
  input  wire logic        I_CMP_HIT,
  input  wire logic        I_SEQ_DONE,
  // sequencer control
  output logic             O_SEQ_START,
  output logic             O_SEQ_ABORT,
  output logic             O_SEQ_ACTIVE,
  output logic             O_INTERNAL_CONVERSION_CLOCK_SEL,
  output logic             O_PRESCALE_EN,
  output logic      [9:0]  O_DIG_BUF_EN,
  output logic             O_IRQ
);
  logic                       rst_m, rst_n;
  logic [14:0]                pin_m, pin_s;
  logic                       stop_s, stop_q, stop_rise, stop_fall;
  logic [9:0]                 an_s;
  logic [3:0]                 trig_s, tcode;
  logic [7:0]                 ctl2, compare_enable_per_conversion, ccf, ccf_set, ccf_clr;
  logic [4:0]                 tsrc;
  logic [1:0]                 ist, imsk, ist_set;
  logic [7:0]                 res [adc_ctl2_pkg::NUM_CONV];
  adc_ctl2_pkg::seq_state_t   state;
  logic                       wr_ctl2, rd_ctl2, wr_res, rd_res, sw_start;
  logic [2:0]                 ridx;
  logic                       span, span_now, src_lvl, src_ok, trig_prev;
  logic                       hit, trig_act, trig_fire;

  // reset release; runs free so that a held enable cannot mask reset
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // pin synchronisers; stop history reads only the second stage
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin_m  <= '0;
      pin_s  <= '0;
      stop_q <= 1'b0;
    end else if (I_CE) begin
      pin_m  <= {I_TRIG_PIN, I_AN_DIG, I_STOP};
      pin_s  <= pin_m;
      stop_q <= pin_s[0];
    end
  end
  assign stop_s = pin_s[0];
  assign an_s   = pin_s[10:1];
  assign trig_s = pin_s[14:11];
  assign stop_rise = stop_s & ~stop_q;
  assign stop_fall = ~stop_s & stop_q;

  // decode
  assign wr_ctl2  = I_WR & (I_ADDR == adc_ctl2_pkg::OFS_CTL2);
  assign rd_ctl2  = I_RD & (I_ADDR == adc_ctl2_pkg::OFS_CTL2);
  assign wr_res   = I_WR & (I_ADDR[7:3] == adc_ctl2_pkg::OFS_RES);
  assign rd_res   = I_RD & (I_ADDR[7:3] == adc_ctl2_pkg::OFS_RES);
  assign ridx     = I_ADDR[2:0];
  assign sw_start = I_WR & (I_ADDR == adc_ctl2_pkg::OFS_START);
  assign tcode    = tsrc[3:0];

  // configuration registers, writable in any mode
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctl2 <= adc_ctl2_pkg::CTL2_RST;
      tsrc <= adc_ctl2_pkg::TSRC_RST;
      compare_enable_per_conversion <= adc_ctl2_pkg::REG_RST;
      imsk <= adc_ctl2_pkg::IST_RST;
    end else if (I_CE && I_WR) begin
      if (I_ADDR == adc_ctl2_pkg::OFS_CTL2) begin
        ctl2 <= I_WDATA & adc_ctl2_pkg::CTL2_WMASK;
      end
      if (I_ADDR == adc_ctl2_pkg::OFS_TSRC) begin
        tsrc <= I_WDATA[4:0];
      end
      if (I_ADDR == adc_ctl2_pkg::OFS_COMPARE_ENABLE_PER_CONVERSION) begin
        compare_enable_per_conversion <= I_WDATA;
      end
      if (I_ADDR == adc_ctl2_pkg::OFS_IMSK) begin
        imsk <= I_WDATA[1:0];
      end
    end
  end
  // trigger source selection
  always_comb begin
    src_lvl = 1'b0;
    src_ok  = 1'b0;
    if (!tsrc[adc_ctl2_pkg::BIT_TSEL]) begin
      src_ok = 1'b1;
      if (tcode > adc_ctl2_pkg::LAST_CH) begin
        src_lvl = an_s[adc_ctl2_pkg::LAST_CH];
      end else begin
        src_lvl = an_s[tcode];
      end
    end else if (tcode < adc_ctl2_pkg::NUM_TRIG) begin
      src_ok  = 1'b1;
      src_lvl = trig_s[tcode[1:0]];
    end
  end

  // sensitivity decode
  always_comb begin
    if (ctl2[adc_ctl2_pkg::BIT_TLE]) begin
      hit = (src_lvl == ctl2[adc_ctl2_pkg::BIT_TPOL]);
    end else if (ctl2[adc_ctl2_pkg::BIT_TPOL]) begin
      hit = src_lvl & ~trig_prev;
    end else begin
      hit = ~src_lvl & trig_prev;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev <= 1'b0;
    end else if (I_CE) begin
      trig_prev <= src_lvl;
    end
  end

  // edges seen mid-sequence are dropped, not queued
  assign trig_act  = ctl2[adc_ctl2_pkg::BIT_TEN] & src_ok & ~stop_s;
  assign trig_fire = trig_act & hit & (state == adc_ctl2_pkg::ST_IDLE);

  // sequence control
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state       <= adc_ctl2_pkg::ST_IDLE;
      O_SEQ_START <= 1'b0;
      O_SEQ_ABORT <= 1'b0;
    end else if (I_CE) begin
      O_SEQ_START <= 1'b0;
      O_SEQ_ABORT <= 1'b0;
      if (wr_ctl2) begin
        state       <= adc_ctl2_pkg::ST_IDLE;
        O_SEQ_ABORT <= (state != adc_ctl2_pkg::ST_IDLE);
      end else begin
        unique case (state)
          adc_ctl2_pkg::ST_IDLE: begin
            if (sw_start || trig_fire) begin
              state       <= adc_ctl2_pkg::ST_RUN;
              O_SEQ_START <= 1'b1;
            end
          end
          adc_ctl2_pkg::ST_RUN: begin
            if (stop_rise && !ctl2[adc_ctl2_pkg::BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE]) begin
              state       <= adc_ctl2_pkg::ST_PARK;
              O_SEQ_ABORT <= 1'b1;
            end else if (I_SEQ_DONE) begin
              state <= adc_ctl2_pkg::ST_IDLE;
            end
          end
          adc_ctl2_pkg::ST_PARK: begin
            if (stop_fall) begin
              state       <= adc_ctl2_pkg::ST_RUN;
              O_SEQ_START <= 1'b1;
            end
          end
          default: begin
            state <= adc_ctl2_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end
  assign O_SEQ_ACTIVE = (state == adc_ctl2_pkg::ST_RUN);

  // clock source; software must wait out recovery after stop exit
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_INTERNAL_CONVERSION_CLOCK_SEL    <= 1'b0;
      O_PRESCALE_EN <= 1'b1;
      O_DIG_BUF_EN  <= '0;
    end else if (I_CE) begin
      O_INTERNAL_CONVERSION_CLOCK_SEL    <= stop_s & ctl2[adc_ctl2_pkg::BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE];
      O_PRESCALE_EN <= ~(stop_s & ctl2[adc_ctl2_pkg::BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE]);
      O_DIG_BUF_EN  <= '0;
      if (ctl2[adc_ctl2_pkg::BIT_TEN] && !tsrc[adc_ctl2_pkg::BIT_TSEL]) begin
        if (tcode > adc_ctl2_pkg::LAST_CH) begin
          O_DIG_BUF_EN[adc_ctl2_pkg::LAST_CH] <= 1'b1;
        end else begin
          O_DIG_BUF_EN[tcode] <= 1'b1;
        end
      end
    end
  end

  // a run/stop change during a conversion spoils that conversion
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      span <= 1'b0;
    end else if (I_CE) begin
      if (I_CONV_BEGIN || I_CONV_DONE) begin
        span <= I_CONV_BEGIN & (stop_rise | stop_fall);
      end else if (stop_rise || stop_fall) begin
        span <= 1'b1;
      end
    end
  end
  assign span_now = span | stop_rise | stop_fall;

  // complete flags: set beats clear
  always_comb begin
    ccf_set = '0;
    ccf_clr = '0;
    if (I_CONV_DONE && !span_now) begin
      ccf_set[I_CONV_IDX] = ~compare_enable_per_conversion[I_CONV_IDX] | I_CMP_HIT;
    end
    if (I_WR && I_ADDR == adc_ctl2_pkg::OFS_FLAG &&
        !ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL]) begin
      ccf_clr = I_WDATA;
    end
    if (ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL]) begin
      if (rd_res && !compare_enable_per_conversion[ridx]) begin
        ccf_clr[ridx] = 1'b1;
      end
      if (wr_res && compare_enable_per_conversion[ridx]) begin
        ccf_clr[ridx] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ccf <= adc_ctl2_pkg::REG_RST;
    end else if (I_CE) begin
      ccf <= (ccf & ~ccf_clr) | ccf_set;
    end
  end

  // results; a write in compare mode loads the compare reference
  always_ff @(posedge I_CLOCK) begin
    if (I_CE && rst_n) begin
      if (I_CONV_DONE && !span_now) begin
        res[I_CONV_IDX] <= I_CONV_DATA;
      end else if (wr_res && compare_enable_per_conversion[ridx]) begin
        res[ridx] <= I_WDATA;
      end
    end
  end

  // interrupt status, write one to clear, set wins
  always_comb begin
    ist_set = '0;
    ist_set[adc_ctl2_pkg::IST_SEQ] = I_SEQ_DONE &&
                                     state == adc_ctl2_pkg::ST_RUN;
    ist_set[adc_ctl2_pkg::IST_CMP] = |(ccf_set & compare_enable_per_conversion);
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ist   <= adc_ctl2_pkg::IST_RST;
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      if (I_WR && I_ADDR == adc_ctl2_pkg::OFS_IST) begin
        ist <= (ist & ~I_WDATA[1:0]) | ist_set;
      end else begin
        ist <= ist | ist_set;
      end
      O_IRQ <= |(ist & imsk);
    end
  end

  // read port; data stand only in the cycle after the strobe
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_RDATA <= '0;
    end else if (I_CE) begin
      O_RDATA <= '0;
      if (rd_res) begin
        O_RDATA <= res[ridx];
      end else if (I_RD) begin
        unique case (I_ADDR)
          adc_ctl2_pkg::OFS_CTL2:  O_RDATA <= {1'b0, ctl2[6:0]};
          adc_ctl2_pkg::OFS_TSRC:  O_RDATA <= {3'h0, tsrc};
          adc_ctl2_pkg::OFS_FLAG:  O_RDATA <= ccf;
          adc_ctl2_pkg::OFS_COMPARE_ENABLE_PER_CONVERSION:  O_RDATA <= compare_enable_per_conversion;
          adc_ctl2_pkg::OFS_IST:   O_RDATA <= {6'h00, ist};
          adc_ctl2_pkg::OFS_IMSK:  O_RDATA <= {6'h00, imsk};
          default:                 O_RDATA <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!rst_n);
  property p_abort;
    I_CE && wr_ctl2 && state != adc_ctl2_pkg::ST_IDLE
      |=> O_SEQ_ABORT && state == adc_ctl2_pkg::ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("write did not abort");
  property p_w1c;
    I_CE && I_WR && I_ADDR == adc_ctl2_pkg::OFS_FLAG && I_WDATA[2] &&
      !ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL] && !ccf_set[2] |=> !ccf[2];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_fast_rd;
    I_CE && rd_res && ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL] && !compare_enable_per_conversion[ridx] &&
      !ccf_set[ridx] |=> !ccf[$past(ridx)];
  endproperty
  a_fast_rd: assert property (p_fast_rd) else $error("read kept flag");
  property p_fast_wr;
    I_CE && wr_res && ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL] && compare_enable_per_conversion[ridx] &&
      !ccf_set[ridx] |=> !ccf[$past(ridx)];
  endproperty
  a_fast_wr: assert property (p_fast_wr) else $error("write kept flag");
  property p_internal_conversion_clock;
    I_CE && stop_s && ctl2[adc_ctl2_pkg::BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE]
      |=> O_INTERNAL_CONVERSION_CLOCK_SEL && !O_PRESCALE_EN;
  endproperty
  a_internal_conversion_clock: assert property (p_internal_conversion_clock) else $error("no internal clock");
  property p_stop_trig;
    I_CE && stop_s && !sw_start |=> !O_SEQ_START || $past(stop_fall);
  endproperty
  a_stop_trig: assert property (p_stop_trig) else $error("start in stop");
  property p_span;
    I_CE && I_CONV_DONE && span_now && !ccf[I_CONV_IDX]
      |=> !ccf[$past(I_CONV_IDX)];
  endproperty
  a_span: assert property (p_span) else $error("spoilt flag set");
  property p_park;
    I_CE && state == adc_ctl2_pkg::ST_RUN && stop_rise && !wr_ctl2 &&
      !ctl2[adc_ctl2_pkg::BIT_STOP_MODE_INTERNAL_CLOCK_ENABLE]
      |=> O_SEQ_ABORT && state == adc_ctl2_pkg::ST_PARK;
  endproperty
  a_park: assert property (p_park) else $error("not parked");
  property p_restart;
    I_CE && state == adc_ctl2_pkg::ST_PARK && stop_fall && !wr_ctl2
      |=> O_SEQ_START && O_SEQ_ACTIVE;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  // codes above nine fold onto the last channel
  property p_dbuf;
    I_CE && ctl2[adc_ctl2_pkg::BIT_TEN] && tsrc == 5'h0c
      |=> O_DIG_BUF_EN == 10'h200;
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("buffer not on");
  property p_level;
    I_CE && state == adc_ctl2_pkg::ST_IDLE && !wr_ctl2 && trig_act &&
      ctl2[adc_ctl2_pkg::BIT_TLE] && ctl2[adc_ctl2_pkg::BIT_TPOL] && src_lvl
      |=> O_SEQ_START && O_SEQ_ACTIVE;
  endproperty
  a_level: assert property (p_level) else $error("trigger missed");
  property p_seq_irq;
    I_CE && I_SEQ_DONE && state == adc_ctl2_pkg::ST_RUN
      |=> ist[adc_ctl2_pkg::IST_SEQ];
  endproperty
  a_seq_irq: assert property (p_seq_irq) else $error("no seq event");
  property p_rsv;
    I_CE && rd_ctl2 |=> !O_RDATA[7];
  endproperty
  a_rsv: assert property (p_rsv) else $error("bit 7 set");
  property p_cov_park;
    state == adc_ctl2_pkg::ST_PARK ##[1:200] O_SEQ_START;
  endproperty
  c_park: cover property (p_cov_park);
  property p_cov_trig;
    trig_fire ##1 O_SEQ_START;
  endproperty
  c_trig: cover property (p_cov_trig);
  property p_cov_fast;
    ccf[3] ##1 rd_res && ridx == 3'h3 && ctl2[adc_ctl2_pkg::BIT_FAST_FLAG_CLEAR_ALL]
      ##1 !ccf[3];
  endproperty
  c_fast: cover property (p_cov_fast);
endmodule
`default_nettype wire

// ==== test/adc_ctl2_core_tb.sv ====
// self-checking bench for the converter control-two block
`timescale 1ns/1ps
`default_nettype none
module adc_ctl2_core_tb;
  logic       clk;
  logic       arst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       stop;
  logic [9:0] an_dig;
  logic [3:0] trig_pin;
  logic       cbeg;
  logic       cdone;
  logic [2:0] cidx;
  logic [7:0] cdata;
  logic       chit;
  logic       sdone;
  logic       seq_start;
  logic       seq_abort;
  logic       seq_active;
  logic       internal_conversion_clock_sel;
  logic       prescale_en;
  logic [9:0] dig_buf_en;
  logic       irq;
  logic       ce;
  int         mismatches;
  int         checks_done;
  int         cycles;
  int         n_start;
  int         n_abort;
  int         s0;
  int         a0;
  logic       an;
  logic       le;
  logic       pol;

  adc_ctl2_core i_dut (
    .I_CLOCK       (clk),
    .I_ARST_N      (arst_n),
    .I_CE          (ce),
    .I_ADDR        (addr),
    .I_WDATA       (wdata),
    .I_WR          (wr),
    .I_RD          (rd),
    .O_RDATA       (rdata),
    .I_STOP        (stop),
    .I_AN_DIG      (an_dig),
    .I_TRIG_PIN    (trig_pin),
    .I_CONV_BEGIN  (cbeg),
    .I_CONV_DONE   (cdone),
    .I_CONV_IDX    (cidx),
    .I_CONV_DATA   (cdata),
    .I_CMP_HIT     (chit),
    .I_SEQ_DONE    (sdone),
    .O_SEQ_START   (seq_start),
    .O_SEQ_ABORT   (seq_abort),
    .O_SEQ_ACTIVE  (seq_active),
    .O_INTERNAL_CONVERSION_CLOCK_SEL    (internal_conversion_clock_sel),
    .O_PRESCALE_EN (prescale_en),
    .O_DIG_BUF_EN  (dig_buf_en),
    .O_IRQ         (irq)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // pulses are counted here so checks need not land on the exact cycle
  always @(posedge clk) begin
    if (seq_start === 1'b1) n_start <= n_start + 1;
    if (seq_abort === 1'b1) n_abort <= n_abort + 1;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hang would otherwise stall the run forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk({2'h0, rdata}, {2'h0, exp});
  endtask

  // flip moves stop across the conversion, so its result must be dropped
  task automatic conv(input logic [2:0] idx, input logic [7:0] d,
                      input logic hit, input bit flip);
    @(posedge clk);
    cbeg <= 1'b1;
    @(posedge clk);
    cbeg <= 1'b0;
    if (flip) stop <= 1'b1;
    repeat (flip ? 6 : 1) @(posedge clk);
    cdone <= 1'b1;
    cidx  <= idx;
    cdata <= d;
    chit  <= hit;
    @(posedge clk);
    cdone <= 1'b0;
    cyc(2);
  endtask

  task automatic seq_end();
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    cyc(2);
  endtask

  task automatic set_lvl(input logic on_an, input logic v);
    @(posedge clk);
    if (on_an) an_dig[9] <= v;
    else trig_pin[0] <= v;
    cyc(3);
  endtask

  initial begin
    arst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    stop = 1'b0; an_dig = 10'h000; trig_pin = 4'h0; cbeg = 1'b0;
    cdone = 1'b0; cidx = 3'h0; cdata = 8'h00; chit = 1'b0; sdone = 1'b0;
    mismatches = 0; checks_done = 0; cycles = 0; n_start = 0; n_abort = 0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    cyc(3);
    // reset values and reserved bit
    rd_chk(8'h02, 8'h00);
    chk({9'h0, prescale_en}, 10'h1);
    chk({9'h0, internal_conversion_clock_sel}, 10'h0);
    wr_reg(8'h02, 8'hff);
    rd_chk(8'h02, 8'h7f);
    wr_reg(8'h02, 8'h00);
    rd_chk(8'h30, 8'h00);
    // control-two write aborts a running sequence only
    s0 = n_start;
    wr_reg(8'h13, 8'h00);
    cyc(2);
    chk(10'(n_start - s0), 10'h1);
    a0 = n_abort;
    wr_reg(8'h02, 8'h00);
    cyc(2);
    chk(10'(n_abort - a0), 10'h1);
    chk({9'h0, seq_active}, 10'h0);
    wr_reg(8'h02, 8'h00);
    cyc(2);
    chk(10'(n_abort - a0), 10'h1);
    // flag clearing by write-one
    conv(3'h2, 8'h5a, 1'b0, 1'b0);
    rd_chk(8'h11, 8'h04);
    rd_chk(8'h22, 8'h5a);
    rd_chk(8'h11, 8'h04);
    wr_reg(8'h11, 8'h04);
    rd_chk(8'h11, 8'h00);
    // fast clear: read clears without compare, write clears with it
    wr_reg(8'h02, 8'h40);
    conv(3'h3, 8'h33, 1'b0, 1'b0);
    rd_chk(8'h11, 8'h08);
    rd_chk(8'h23, 8'h33);
    rd_chk(8'h11, 8'h00);
    wr_reg(8'h12, 8'h10);
    conv(3'h4, 8'h44, 1'b1, 1'b0);
    rd_chk(8'h24, 8'h44);
    rd_chk(8'h11, 8'h10);
    wr_reg(8'h24, 8'h80);
    rd_chk(8'h11, 8'h00);
    wr_reg(8'h12, 8'h00);
    wr_reg(8'h14, 8'hff);
    // stop with internal clock: sequence keeps going
    set_lvl(1'b0, 1'b1);
    wr_reg(8'h15, 8'h01);
    wr_reg(8'h10, 8'h10);
    wr_reg(8'h02, 8'h24);
    wr_reg(8'h13, 8'h00);
    a0 = n_abort;
    conv(3'h5, 8'h55, 1'b0, 1'b1);
    chk({9'h0, internal_conversion_clock_sel}, 10'h1);
    chk({9'h0, prescale_en}, 10'h0);
    chk({9'h0, seq_active}, 10'h1);
    chk(10'(n_abort - a0), 10'h0);
    rd_chk(8'h11, 8'h00);
    seq_end();
    chk({9'h0, irq}, 10'h1);
    s0 = n_start;
    set_lvl(1'b0, 1'b0);
    cyc(3);
    chk(10'(n_start - s0), 10'h0);
    wr_reg(8'h14, 8'h01);
    cyc(2);
    chk({9'h0, irq}, 10'h0);
    set_lvl(1'b0, 1'b1);
    @(posedge clk);
    stop <= 1'b0;
    cyc(6);
    chk({9'h0, prescale_en}, 10'h1);
    chk(10'(n_start - s0), 10'h0);
    // stop without internal clock: abort, then restart on exit
    wr_reg(8'h02, 8'h00);
    wr_reg(8'h13, 8'h00);
    cyc(2);
    a0 = n_abort;
    s0 = n_start;
    @(posedge clk);
    stop <= 1'b1;
    cyc(6);
    chk(10'(n_abort - a0), 10'h1);
    chk({9'h0, seq_active}, 10'h0);
    @(posedge clk);
    stop <= 1'b0;
    cyc(6);
    chk(10'(n_start - s0), 10'h1);
    chk({9'h0, seq_active}, 10'h1);
    // a masked status bit must not raise the interrupt
    wr_reg(8'h15, 8'h00);
    seq_end();
    chk({9'h0, irq}, 10'h0);
    rd_chk(8'h14, 8'h01);
    wr_reg(8'h14, 8'h01);
    rd_chk(8'h14, 8'h00);
    // every sensitivity on a dedicated pin and on channel code 12
    for (int m = 0; m < 8; m++) begin
      an  = m[2];
      le  = m[1];
      pol = m[0];
      wr_reg(8'h02, 8'h00);
      set_lvl(an, ~pol);
      wr_reg(8'h10, an ? 8'h0c : 8'h10);
      wr_reg(8'h02, {3'h0, le, pol, 3'h4});
      cyc(4);
      chk(dig_buf_en, an ? 10'h200 : 10'h000);
      s0 = n_start;
      set_lvl(an, pol);
      cyc(3);
      chk(10'(n_start - s0), 10'h1);
      chk({9'h0, seq_active}, 10'h1);
      set_lvl(an, ~pol);
      seq_end();
    end
    // trigger disabled: no start and no input buffer
    wr_reg(8'h02, 8'h08);
    set_lvl(1'b1, 1'b0);
    chk(dig_buf_en, 10'h000);
    s0 = n_start;
    set_lvl(1'b1, 1'b1);
    cyc(3);
    chk(10'(n_start - s0), 10'h0);
    // a low enable must leave the register untouched
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h02, 8'h44);
    ce <= 1'b1;
    rd_chk(8'h02, 8'h08);
    conclude();
  end
endmodule
`default_nettype wire
